// [rtl/cics_cfg_if.sv]
// raw setup word and strap inputs carried from the register to the pin steering
// assumes one producer and one consumer in the same clock domain
`timescale 1ns/1ps
`default_nettype none
interface cics_cfg_if;
    logic [15:0] setup;
    logic [1:0]  config_pins;
    logic [1:0]  configuration_status;
    modport reg_side (output setup, output config_pins, output configuration_status);
    modport mux_side (input setup, input config_pins, input configuration_status);
endinterface
`default_nettype wire

// [rtl/cics_pin_steer.sv]
// pin steering: turns the setup register into bus routing and drive modes
// assumes the setup word is registered by the parent
`timescale 1ns/1ps
`default_nettype none
module cics_pin_steer (
    cics_cfg_if.mux_side cfg,
    // decoded controls
    output logic        alt_pin_select_o,
    output logic [6:0]  bus_address_o,
    output logic        serial_peripheral_enable_o,
    output logic        four_wire_select_o,
    output logic        separate_serial_out_od_o,
    output logic        address_auto_increment_o
);
    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic [6:0] cics_addr(input logic [1:0] sel);
        case (sel)
            2'h0:    cics_addr = cics_pkg::BUS_ADDR_0;
            2'h1:    cics_addr = cics_pkg::BUS_ADDR_1;
            2'h2:    cics_addr = cics_pkg::BUS_ADDR_2;
            default: cics_addr = cics_pkg::BUS_ADDR_3;
        endcase
    endfunction

    // field gating; outer enables mask inner selections
    always_comb begin
        serial_peripheral_enable_o = cfg.setup[cics_pkg::SPI_EN_BIT];
        four_wire_select_o = serial_peripheral_enable_o
                           & cfg.setup[cics_pkg::FOUR_WIRE_BIT];
        separate_serial_out_od_o = four_wire_select_o
                                 & cfg.setup[cics_pkg::OD_BIT];
        alt_pin_select_o = cfg.setup[cics_pkg::ALT_PIN_BIT]
                         & (cfg.config_pins == cics_pkg::CFG_PINS_DEV);
        // outside the valid status the first address is used
        bus_address_o = (cfg.configuration_status == cics_pkg::CFG_STS_DEV)
                      ? cics_addr(cfg.setup[cics_pkg::ADDR_SEL_HI:cics_pkg::ADDR_SEL_LO])
                      : cics_pkg::BUS_ADDR_0;
        address_auto_increment_o = cfg.setup[cics_pkg::ADDRESS_AUTO_INCREMENT_BIT];
    end
endmodule
`default_nettype wire

// [rtl/cics_pkg.sv]
// constants for the control interface setup register block
// assumes a 16-bit register port addressed by register index
`default_nettype none
package cics_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0]  SETUP_OFFSET   = 8'h06;
    localparam int          REG_W          = 16;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int          ALT_PIN_BIT    = 15;
    localparam int          ADDR_SEL_HI    = 14;
    localparam int          ADDR_SEL_LO    = 13;
    localparam int          DONE_BIT       = 12;
    localparam int          RECONF_BIT     = 11;
    localparam int          ADDRESS_AUTO_INCREMENT_BIT    = 9;
    localparam int          OD_BIT         = 3;
    localparam int          FOUR_WIRE_BIT  = 2;
    localparam int          SPI_EN_BIT     = 1;
    // writable bits; 10, 8 and 7..4 and 0 read as zero
    localparam logic [15:0] DEFINED_MASK   = 16'hFA0E;
    localparam logic [15:0] KEYED_MASK     = 16'h000E;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [15:0] SETUP_RESET    = 16'h8A00;
    // ----------------------------------------
    // bus addresses and pin codes
    // ----------------------------------------
    localparam logic [6:0]  BUS_ADDR_0     = 7'h34;
    localparam logic [6:0]  BUS_ADDR_1     = 7'h36;
    localparam logic [6:0]  BUS_ADDR_2     = 7'h3C;
    localparam logic [6:0]  BUS_ADDR_3     = 7'h3E;
    localparam logic [1:0]  CFG_PINS_DEV   = 2'h0;
    localparam logic [1:0]  CFG_STS_DEV    = 2'h0;

    typedef enum logic [2:0] {
        CICS_OFF    = 3'b001,
        CICS_LOAD   = 3'b010,
        CICS_ACTIVE = 3'b100
    } cics_pwr_t;
endpackage
`default_nettype wire

// [rtl/cics_setup_reg.sv]
// control interface setup register with power-event reload control
// assumes a synchronous register port from the serial engine
`timescale 1ns/1ps
`default_nettype none
module cics_setup_reg (
    // clock, reset, enable
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic [15:0]      reg_rdata_o,
    // security and straps
    input  wire logic        key_unlocked_i,
    input  wire logic [1:0]  config_pins_i,
    input  wire logic [1:0]  configuration_status_i,
    input  wire logic        dev_mode_i,
    // power events
    input  wire logic        on_event_i,
    input  wire logic        off_event_i,
    input  wire logic        sm_reset_i,
    // configuration loader
    input  wire logic        load_done_i,
    output logic             load_request_o,
    output logic             config_done_o,
    output logic             regs_reset_o,
    // decoded controls
    output logic             alt_pin_select_o,
    output logic [6:0]       bus_address_o,
    output logic             serial_peripheral_enable_o,
    output logic             four_wire_select_o,
    output logic             separate_serial_out_od_o,
    output logic             address_auto_increment_o
);
    logic [15:0]         setup_q;
    cics_pkg::cics_pwr_t state_q;
    logic                first_q;
    logic                hit;
    logic [15:0]         wmask;
    logic [15:0]         sm_mask;

    cics_cfg_if cfg ();
    assign cfg.setup                = setup_q;
    assign cfg.config_pins          = config_pins_i;
    assign cfg.configuration_status = configuration_status_i;

    // ----------------------------------------
    // register write path
    // ----------------------------------------
    // keyed bits drop out of the mask while locked
    always_comb begin
        hit   = reg_wr_i & (reg_addr_i == cics_pkg::SETUP_OFFSET);
        wmask = cics_pkg::DEFINED_MASK;
        if (!key_unlocked_i) begin
            wmask = wmask & ~cics_pkg::KEYED_MASK;
        end
        sm_mask = 16'h0000;
        sm_mask[cics_pkg::ALT_PIN_BIT] = 1'b1;
        sm_mask[cics_pkg::ADDR_SEL_HI] = 1'b1;
        sm_mask[cics_pkg::ADDR_SEL_LO] = 1'b1;
        sm_mask[cics_pkg::DONE_BIT]    = 1'b1;
        sm_mask[cics_pkg::ADDRESS_AUTO_INCREMENT_BIT] = 1'b1;
    end

    // register state; loader completion wins over a software write
    // and over a same-cycle field reset, so a finished load is never lost
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            setup_q <= cics_pkg::SETUP_RESET;
        end else if (clk_en_i) begin
            if (sm_reset_i || regs_reset_o) begin
                // metal-mask bits kept; loaded fields back to defaults
                setup_q <= (setup_q & ~sm_mask) | (cics_pkg::SETUP_RESET & sm_mask);
            end else if (hit) begin
                setup_q <= (setup_q & ~wmask) | (reg_wdata_i & wmask);
            end
            // completion set placed last so that it wins
            if (state_q == cics_pkg::CICS_LOAD && load_done_i) begin
                setup_q[cics_pkg::DONE_BIT] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // power event sequencing
    // ----------------------------------------
    // first power-up in development mode always loads
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= cics_pkg::CICS_OFF;
            first_q <= 1'b1;
        end else if (clk_en_i) begin
            case (state_q)
                cics_pkg::CICS_OFF: begin
                    if (on_event_i) begin
                        if (setup_q[cics_pkg::RECONF_BIT] || (first_q && dev_mode_i)) begin
                            state_q <= cics_pkg::CICS_LOAD;
                        end else begin
                            state_q <= cics_pkg::CICS_ACTIVE;
                        end
                        first_q <= 1'b0;
                    end
                end
                cics_pkg::CICS_LOAD: begin
                    if (load_done_i) begin
                        state_q <= cics_pkg::CICS_ACTIVE;
                    end
                end
                cics_pkg::CICS_ACTIVE: begin
                    if (off_event_i) begin
                        state_q <= cics_pkg::CICS_OFF;
                    end
                end
                default: state_q <= cics_pkg::CICS_OFF;
            endcase
        end
    end

    // register reset held while off with reconfigure set
    assign regs_reset_o   = (state_q == cics_pkg::CICS_OFF) & setup_q[cics_pkg::RECONF_BIT];
    assign load_request_o = (state_q == cics_pkg::CICS_LOAD);
    assign config_done_o  = setup_q[cics_pkg::DONE_BIT]
                          & (config_pins_i == cics_pkg::CFG_PINS_DEV);

    // read data straight from the register, undefined bits zero
    always_comb begin
        reg_rdata_o = (reg_addr_i == cics_pkg::SETUP_OFFSET)
                    ? (setup_q & cics_pkg::DEFINED_MASK) : 16'h0000;
    end

    cics_pin_steer u_steer (
        .cfg                        (cfg.mux_side),
        .alt_pin_select_o           (alt_pin_select_o),
        .bus_address_o              (bus_address_o),
        .serial_peripheral_enable_o (serial_peripheral_enable_o),
        .four_wire_select_o         (four_wire_select_o),
        .separate_serial_out_od_o   (separate_serial_out_od_o),
        .address_auto_increment_o   (address_auto_increment_o)
    );

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // properties over the register, the power sequencing and the pin steering
    AST_KEY_LOCK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (hit && !key_unlocked_i && clk_en_i && !sm_reset_i && !regs_reset_o)
        |=> $stable(setup_q[3:1])) else $error("keyed bits changed while locked");
    AST_UNDEF_ZERO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (reg_rdata_o & ~cics_pkg::DEFINED_MASK) == 16'h0000) else $error("undefined bit read nonzero");
    AST_SM_RESET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (sm_reset_i && clk_en_i) |=> (setup_q[15:13] == 3'h4 && setup_q[9]
        && setup_q[12] == ($past(load_request_o) && $past(load_done_i)))) else $error("fields not restored");
    AST_RELOAD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q == cics_pkg::CICS_OFF && on_event_i && clk_en_i && setup_q[11])
        |=> load_request_o) else $error("no reload on on event");
    AST_NO_RELOAD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q == cics_pkg::CICS_OFF && on_event_i && clk_en_i && !setup_q[11] && !first_q)
        |=> !load_request_o) else $error("unexpected reload");
    AST_DEV_FIRST: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (first_q && dev_mode_i && on_event_i && clk_en_i && state_q == cics_pkg::CICS_OFF)
        |=> load_request_o) else $error("first dev load missing");
    AST_OD_GATE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !four_wire_select_o |-> !separate_serial_out_od_o) else $error("drive applied without four wire");
    AST_FOUR_GATE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !serial_peripheral_enable_o |-> !four_wire_select_o) else $error("four wire without spi");
    AST_DONE_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (load_request_o && load_done_i && clk_en_i) |=> setup_q[12]) else $error("done not set");
    AST_ADDR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (configuration_status_i == 2'h0 && setup_q[14:13] == 2'h2) |-> bus_address_o == 7'h3C)
        else $error("bad bus address");

    // off-state handling, stored bits and the decoded controls
    AST_OFF_RESET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (regs_reset_o && clk_en_i) |=> (setup_q[15:12] == 4'h8 && setup_q[9])) else $error("off reset missing");
    AST_OFF_KEEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q == cics_pkg::CICS_OFF && !setup_q[11] && !hit && !sm_reset_i)
        |=> $stable(setup_q)) else $error("registers lost while off");
    AST_UNDEF_HELD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (setup_q & ~cics_pkg::DEFINED_MASK) == 16'h0000) else $error("undefined bit stored");
    AST_ALT_GATE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (config_pins_i != 2'h0) |-> !alt_pin_select_o) else $error("alt pins outside strap 00");
    AST_DONE_GATE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (config_pins_i != 2'h0) |-> !config_done_o) else $error("done flag outside strap 00");
    AST_ADDR_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (configuration_status_i != 2'h0) |-> bus_address_o == 7'h34) else $error("address outside status 00");
    AST_FOUR_SEL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (setup_q[1] && setup_q[2]) |-> four_wire_select_o) else $error("four wire not selected");
    AST_OD_SEL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (four_wire_select_o && setup_q[3]) |-> separate_serial_out_od_o) else $error("open drain not selected");
    AST_SPI_SEL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        serial_peripheral_enable_o == setup_q[1]) else $error("interface select mismatch");
    AST_ADDRESS_AUTO_INCREMENT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        address_auto_increment_o == setup_q[9]) else $error("auto increment mismatch");

    // cover the main scenarios
    COV_LOAD: cover property (@(posedge ref_clk_i) load_request_o ##1 !load_request_o);
    COV_UNLOCK_WR: cover property (@(posedge ref_clk_i) hit && key_unlocked_i && reg_wdata_i[2]);
    COV_OFF_KEEP: cover property (@(posedge ref_clk_i) state_q == cics_pkg::CICS_OFF && !setup_q[11]);
    COV_DEV_FIRST: cover property (@(posedge ref_clk_i) first_q && dev_mode_i && on_event_i && clk_en_i);
    COV_SM_RESET: cover property (@(posedge ref_clk_i) sm_reset_i && clk_en_i && state_q == cics_pkg::CICS_ACTIVE);
endmodule
`default_nettype wire

// [test/cics_loader_model.sv]
// behavioural model of the external configuration controller
// assumes one clock shared with the setup register block
`timescale 1ns/1ps
`default_nettype none
module cics_loader_model (
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // handshake with the device
    input  wire logic       load_request_i,
    input  wire logic [3:0] delay_i,
    output logic            load_done_o
);
    // ----------------------------------------
    // load sequencing
    // ----------------------------------------
    logic [3:0] cnt_q;

    // finish after delay_i+1 cycles of request; one-cycle done pulse
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q       <= 4'h0;
            load_done_o <= 1'b0;
        end else begin
            load_done_o <= 1'b0;
            if (load_request_i && !load_done_o) begin
                if (cnt_q == delay_i) begin
                    load_done_o <= 1'b1;
                    cnt_q       <= 4'h0;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end else begin
                cnt_q <= 4'h0;              // a dropped request restarts the count
            end
        end
    end
endmodule
`default_nettype wire

// [test/control_interface_config_reg_test.sv]
// self-checking bench for the control interface setup register
// assumes cics_setup_reg as top and the loader model beside it
`timescale 1ns/1ps
`default_nettype none
module control_interface_config_reg_test;
    // ----------------------------------------
    // stimulus and wiring
    // ----------------------------------------
    logic ref_clk_i = 1'b0, rst_i = 1'b1, clk_en_i = 1'b1, reg_wr_i = 1'b0, key_unlocked_i = 1'b0;
    logic dev_mode_i = 1'b0, on_event_i = 1'b0, off_event_i = 1'b0, sm_reset_i = 1'b0, load_done;
    logic [7:0]  reg_addr_i = 8'h06;
    logic [15:0] reg_wdata_i = 16'h0000, rd;
    logic [1:0]  config_pins_i = 2'h0, configuration_status_i = 2'h0;
    logic [3:0]  delay = 4'h1;
    logic        req, cdone, rreset, alt, spi, four, od, ainc;
    logic [6:0]  baddr;
    int          err_count = 0, n_tests = 0;
    logic [6:0]  addr_tab [4] = '{7'h34, 7'h36, 7'h3C, 7'h3E};

    cics_setup_reg uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rd), .key_unlocked_i(key_unlocked_i),
        .config_pins_i(config_pins_i), .configuration_status_i(configuration_status_i), .dev_mode_i(dev_mode_i),
        .on_event_i(on_event_i), .off_event_i(off_event_i), .sm_reset_i(sm_reset_i), .load_done_i(load_done),
        .load_request_o(req), .config_done_o(cdone), .regs_reset_o(rreset), .alt_pin_select_o(alt),
        .bus_address_o(baddr), .serial_peripheral_enable_o(spi), .four_wire_select_o(four),
        .separate_serial_out_od_o(od), .address_auto_increment_o(ainc));
    cics_loader_model loader (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .load_request_i(req), .delay_i(delay),
        .load_done_o(load_done));

    // 40 MHz clock
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    // one-cycle pulse on a power event: 0 on, 1 off, 2 state machine reset
    task automatic pulse(input int k);
        @(posedge ref_clk_i);
        if (k == 0) on_event_i <= 1'b1; else if (k == 1) off_event_i <= 1'b1; else sm_reset_i <= 1'b1;
        @(posedge ref_clk_i);
        {on_event_i, off_event_i, sm_reset_i} <= 3'b000;
        #1;
    endtask
    // bounded wait for the load to finish; sampled off the edge, a hang counts as a mismatch
    task automatic wait_load;
        int i;
        for (i = 0; i < 40 && req !== 1'b0; i++) begin
            @(posedge ref_clk_i);
            #1;
        end
        if (i == 40) err_count++;
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_up;
        #1;
        chk("reset value", rd, 16'h8A00);
        pulse(0);
        chk("load request", {15'h0, req}, 16'h0001);
        wait_load();
        chk("loaded word", rd, 16'h9A00);
        chk("config done", {15'h0, cdone}, 16'h0001);
        @(posedge ref_clk_i);
        config_pins_i <= 2'h1;
        #1;
        chk("done off strap", {15'h0, cdone}, 16'h0000);
        chk("alt off strap", {15'h0, alt}, 16'h0000);
        @(posedge ref_clk_i);
        config_pins_i <= 2'h0;
        $display("test power_up done");
    endtask
    task automatic t_fields;
        wr(8'h06, 16'hFFFF);
        chk("locked write", rd, 16'hFA00);
        chk("alt pins", {15'h0, alt}, 16'h0001);
        @(posedge ref_clk_i);
        key_unlocked_i <= 1'b1;
        wr(8'h06, 16'h000C);
        chk("four ineffective", {14'h0, four, od}, 16'h0000);
        wr(8'h06, 16'h000E);
        chk("keyed word", rd, 16'h000E);
        chk("spi four od", {13'h0, spi, four, od}, 16'h0007);
        chk("address_auto_increment off", {15'h0, ainc}, 16'h0000);
        wr(8'h06, 16'h0006);
        chk("cmos drive", {13'h0, spi, four, od}, 16'h0006);
        wr(8'h06, 16'h020A);
        chk("od ineffective", {13'h0, spi, four, od}, 16'h0004);
        chk("address_auto_increment on", {15'h0, ainc}, 16'h0001);
        wr(8'h06, 16'h0008);
        chk("two wire", {15'h0, spi}, 16'h0000);
        wr(8'h06, 16'h000A);
        @(posedge ref_clk_i);
        key_unlocked_i <= 1'b0;
        wr(8'h06, 16'h0000);
        chk("keyed held", rd, 16'h0000 | 16'h000A);
        @(posedge ref_clk_i);
        reg_addr_i <= 8'h07;
        #1;
        chk("other offset", rd, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(8'h06, 16'(i) << 13);
            chk("bus address", {9'h0, baddr}, {9'h0, addr_tab[i]});
        end
        @(posedge ref_clk_i);
        configuration_status_i <= 2'h1;
        #1;
        chk("address off status", {9'h0, baddr}, 16'h0034);
        @(posedge ref_clk_i);
        configuration_status_i <= 2'h0;
        $display("test fields done");
    endtask
    task automatic t_power_cycle;
        pulse(1);
        chk("off keep", rd, 16'h600A);
        chk("off no reset", {15'h0, rreset}, 16'h0000);
        pulse(0);
        chk("keep regs", rd, 16'h600A);
        chk("no reload", {14'h0, req, rreset}, 16'h0000);
        wr(8'h06, 16'h0800);                      // reconfigure back to its default
        @(posedge ref_clk_i);
        delay <= 4'h9;
        pulse(1);
        chk("off reset", {15'h0, rreset}, 16'h0001);
        // the field reset lands one edge after the state goes off
        @(posedge ref_clk_i);
        #1;
        chk("off defaults", rd, 16'h8A0A);
        pulse(0);
        wait_load();
        chk("reloaded", rd, 16'h9A0A);
        wr(8'h06, 16'h6800);
        chk("field write", rd, 16'h680A);
        pulse(2);
        chk("sm reset", rd, 16'h8A0A);
        // clock enable low: neither an off event nor a write may act
        @(posedge ref_clk_i);
        clk_en_i <= 1'b0;
        pulse(1);
        wr(8'h06, 16'h0000);
        chk("frozen state", {15'h0, rreset}, 16'h0000);
        chk("frozen word", rd, 16'h8A0A);
        @(posedge ref_clk_i);
        clk_en_i <= 1'b1;
        $display("test power_cycle done");
    endtask
    // mid-run reset in development mode: the first power-up must load
    task automatic t_dev_reset;
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        dev_mode_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        chk("reset again", rd, 16'h8A00);
        chk("off reset held", {15'h0, rreset}, 16'h0001);
        pulse(0);
        chk("dev first load", {15'h0, req}, 16'h0001);
        wait_load();
        chk("dev loaded", rd, 16'h9A00);
        @(posedge ref_clk_i);
        dev_mode_i <= 1'b0;
        $display("test dev_reset done");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        fork
            begin
                t_power_up();
                t_fields();
                t_power_cycle();
                t_dev_reset();
            end
            begin
                repeat (5000) @(posedge ref_clk_i);
                err_count++;                      // watchdog ran out
            end
        join_any
        print_verdict();
    end
endmodule
`default_nettype wire
